// File: verilog/fmd_params.svh
`ifndef FMD_PARAMS_SVH
`define FMD_PARAMS_SVH
// register addresses on the configuration port
`define FMD_ADDR_OUT_MIN    16'h0100
`define FMD_ADDR_OUT_MAX    16'h0101
`define FMD_ADDR_IN_MIN     16'h0102
`define FMD_ADDR_IN_MAX     16'h0103
`define FMD_ADDR_RANGE      16'h0108
// reset values of the stored fields
`define FMD_RST_OUT_MIN     7'h00
`define FMD_RST_OUT_MAX     7'h7F
`define FMD_RST_IN_MIN      6'h00
`define FMD_RST_IN_MAX      6'h3F
// field positions: duty fields sit at bit 1 upward, flags in the range register
`define FMD_TAG_LSB         1
`define FMD_BIT_FULL        2
`define FMD_BIT_ZERO        3
// duty scale: one unit is 0.2 percent, 500 units is full duty
`define FMD_DUTY_FULL       9'h1F4
`define FMD_DUTY_START      9'h014
`define FMD_DUTY_END_LO     9'h078
`define FMD_DUTY_END_HI     9'h10E
`define FMD_TAG_DIV         24'h00_007F
`define FMD_THR_MUL         24'h00_00F9
`define FMD_THR_DIV         24'h00_003F
`define FMD_THR_HI_BASE     9'h0FB
// carrier and timing figures in their own units
`define FMD_CARRIER_KHZ     48
`define FMD_RAMP_MS_FAST_LO 2
`define FMD_RAMP_MS_FAST_HI 100
`define FMD_RAMP_MS_MID     500
`define FMD_RAMP_MS_LONG    1000
`define FMD_RAMP_MS_MAX     2000
`define FMD_SPIN_RPM        304
`define FMD_SS_EDGES        4'h8
// slew intervals in carrier pulses
`define FMD_SLEW_P0         10'h080
`define FMD_SLEW_P1         10'h100
`define FMD_SLEW_P2         10'h200
// taper fraction: (code+1)*15/512 of one commutation period
`define FMD_TAPER_MUL       24'h00_000F
`define FMD_TAPER_SHIFT     9
`define FMD_IN_SAT          16'hFFFF
`endif

// File: verilog/fmd_pkg.sv
package fmd_pkg;
	// operating modes of the duty controller
	typedef enum logic [1:0] {FMD_DETECT, FMD_SOFT, FMD_STEADY} fmd_mode_type;
	// duty value in 0.2 percent units
	typedef logic [8:0] fmd_duty_type;
endpackage

// File: verilog/fmd_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs; only the second stage is read outside
module fmd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q; // first stage, read only by dout
	logic [W-1:0] meta_d;
	logic [W-1:0] dout_d;

	// next values
	always_comb begin
		meta_d = din;
		dout_d = meta_q;
	end

	// registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= meta_d;
			dout   <= dout_d;
		end
	end
endmodule

// File: verilog/fmd_carrier.sv
`timescale 1ns/1ps
`include "fmd_params.svh"
// fixed-rate carrier: counts one period and compares against a threshold
module fmd_carrier #(
	parameter int PERIOD = 833
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] thresh,
	output logic             pwm_q,
	output logic             wrap_q
);
	logic [15:0] cnt_q; // position inside the carrier period
	logic [15:0] cnt_d;
	logic        pwm_d;
	logic        wrap_d;

	// next values: the period never depends on the input pwm rate
	always_comb begin
		wrap_d = (cnt_q == 16'(PERIOD - 1));
		cnt_d  = wrap_d ? 16'h0000 : cnt_q + 16'h0001; // RQ6
		pwm_d  = (cnt_d < thresh);
	end

	// registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q  <= 16'h0000;
			pwm_q  <= 1'b0;
			wrap_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			pwm_q  <= pwm_d;
			wrap_q <= wrap_d;
		end
	end

	// a wrap flag always marks the first count of a fresh period
	a_carrier_period: assert property (@(posedge clk) disable iff (!arst_n) // RQ6
		wrap_q |-> cnt_q == 16'h0000) else $error("carrier wrap off period start");
	// the count never runs past the fixed period, whatever the threshold
	a_carrier_bound: assert property (@(posedge clk) disable iff (!arst_n) // RQ6
		cnt_q < 16'(PERIOD)) else $error("carrier count past period");
endmodule

// File: verilog/fmd_duty_ctrl.sv
`timescale 1ns/1ps
`include "fmd_params.svh"
// How it works
// RQ1: soft start begins at 4 percent duty
// RQ2: end select picks 24 or 54 percent
// RQ3: two-bit code sets ramp duration
// RQ4: ramp rises linearly, then steady rotation
// RQ5: soft start lasts at least eight hall cycles
// RQ6: output carrier fixed at 48 kHz
// RQ7: controller sends pwm between 7 and 40 kHz
// RQ8: input thresholds scale from six-bit fields
// RQ9: between thresholds target is interpolated linearly
// RQ10: above range hold maximum or full duty
// RQ11: below range hold minimum or zero duty
// RQ12: software keeps maximum settings above minimum
// RQ13: duty slews 0.2 percent per pulse group
// RQ14: slew also applies leaving soft start
// RQ15: duty tapers around each commutation edge
// RQ16: rise and fall tapers timed separately
// RQ17: four-bit code sets taper fraction
// RQ18: high code at maximum, low at minimum
// RQ19: fast spinning rotor at power-up skips soft start
// RQ20: input duty measured per period, taper interpolated
// RQ21: ramp increment from ramp time and span
module fmd_duty_ctrl #(
	parameter int CLK_KHZ = 40000,
	parameter int POLES   = 4
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        pwm_in,
	input  wire logic        hall_in,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        ramp_end_select,
	input  wire logic [1:0]  ramp_time_select,
	input  wire logic [1:0]  slew_rate_select,
	input  wire logic [3:0]  rise_taper_at_max,
	input  wire logic [3:0]  rise_taper_at_min,
	input  wire logic [3:0]  fall_taper_at_max,
	input  wire logic [3:0]  fall_taper_at_min,
	output logic [7:0]       reg_rdata_q,
	output logic             drive_a_q,
	output logic             drive_b_q,
	output logic             steady_q,
	output logic [8:0]       duty_now_q
);
	////////////////////////////////////////////////////////////////////////////
	// derived timing counts
	localparam int PERIOD = CLK_KHZ / `FMD_CARRIER_KHZ;
	// one hall cycle at the skip speed; longer periods count as standing still
	localparam longint SPIN_CYC =
		(64'(CLK_KHZ) * 64'd60_000) / (64'(`FMD_SPIN_RPM) * 64'(POLES / 2));
	localparam int SPAN_LO = `FMD_DUTY_END_LO - `FMD_DUTY_START;
	localparam int SPAN_HI = `FMD_DUTY_END_HI - `FMD_DUTY_START;

	// a*b/c with wide intermediate, reused by every scaling stage except the taper lengths and the ramp step interval
	function automatic logic [23:0] fmd_muldiv(input logic [23:0] a, input logic [23:0] b,
		input logic [23:0] c);
		logic [47:0] p;
		p = a * b;
		fmd_muldiv = 24'(p / {24'h00_0000, c});
	endfunction

	// taper numerator between the low and high codes by the output duty
	function automatic logic [23:0] fmd_interp(input logic [3:0] lo, input logic [3:0] hi,
		input logic [8:0] d, input logic [8:0] dmin, input logic [8:0] dmax);
		logic [23:0] nl;
		logic [23:0] nh;
		nl = (24'(lo) + 24'h00_0001) * `FMD_TAPER_MUL; // RQ17
		nh = (24'(hi) + 24'h00_0001) * `FMD_TAPER_MUL;
		if (dmax <= dmin || d <= dmin)
			fmd_interp = nl; // RQ18
		else if (d >= dmax)
			fmd_interp = nh; // RQ18
		else
			fmd_interp = 24'((nl * 24'(dmax - d) + nh * 24'(d - dmin)) / 24'(dmax - dmin)); // RQ20
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// synchronised pins and edges
	logic pwm_s;  // input pwm after two flops
	logic hall_s; // hall level after two flops
	logic pwm_p_q;
	logic hall_p_q;
	logic pwm_rise;
	logic hall_rise;
	logic hall_edge;

	fmd_sync #(.W(2)) u_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.din    ({pwm_in, hall_in}),
		.dout   ({pwm_s, hall_s})
	);

	assign pwm_rise  = pwm_s & ~pwm_p_q;
	assign hall_rise = hall_s & ~hall_p_q;
	assign hall_edge = hall_s ^ hall_p_q;

	////////////////////////////////////////////////////////////////////////////
	// configuration registers
	logic [6:0] omin_q; // min output duty code
	logic [6:0] omax_q; // max output duty code
	logic [5:0] imin_q; // min input threshold code
	logic [5:0] imax_q; // max input threshold code
	logic       full_q; // above range goes to full duty
	logic       zero_q; // below range goes to zero duty
	logic [6:0] omin_d, omax_d;
	logic [5:0] imin_d, imax_d;
	logic       full_d, zero_d;
	logic [7:0] rdata_d;

	// writes land at the printed addresses; unmapped addresses read zero
	always_comb begin
		omin_d   = omin_q;
		omax_d   = omax_q;
		imin_d   = imin_q;
		imax_d   = imax_q;
		full_d   = full_q;
		zero_d   = zero_q;
		if (reg_we) begin
			case (reg_addr)
				`FMD_ADDR_OUT_MIN: omin_d = reg_wdata[7:`FMD_TAG_LSB];
				`FMD_ADDR_OUT_MAX: omax_d = reg_wdata[7:`FMD_TAG_LSB];
				`FMD_ADDR_IN_MIN:  imin_d = reg_wdata[6:`FMD_TAG_LSB];
				`FMD_ADDR_IN_MAX:  imax_d = reg_wdata[6:`FMD_TAG_LSB];
				`FMD_ADDR_RANGE: begin
					full_d = reg_wdata[`FMD_BIT_FULL];
					zero_d = reg_wdata[`FMD_BIT_ZERO];
				end
				default: ; // unmapped write ignored
			endcase
		end
		case (reg_addr)
			`FMD_ADDR_OUT_MIN: rdata_d = {omin_q, 1'b0};
			`FMD_ADDR_OUT_MAX: rdata_d = {omax_q, 1'b0};
			`FMD_ADDR_IN_MIN:  rdata_d = {1'b0, imin_q, 1'b0};
			`FMD_ADDR_IN_MAX:  rdata_d = {1'b0, imax_q, 1'b0};
			`FMD_ADDR_RANGE:  rdata_d = {4'h0, zero_q, full_q, 2'h0};
			default:          rdata_d = 8'h00;
		endcase
	end

	// register file
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			omin_q      <= `FMD_RST_OUT_MIN;
			omax_q      <= `FMD_RST_OUT_MAX;
			imin_q      <= `FMD_RST_IN_MIN;
			imax_q      <= `FMD_RST_IN_MAX;
			full_q      <= 1'b0;
			zero_q      <= 1'b0;
			reg_rdata_q <= 8'h00;
		end else begin
			omin_q      <= omin_d;
			omax_q      <= omax_d;
			imin_q      <= imin_d;
			imax_q      <= imax_d;
			full_q      <= full_d;
			zero_q      <= zero_d;
			reg_rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input duty measurement and target map
	logic [15:0] per_q, hi_q; // running period and high-time counts
	logic [15:0] per_d, hi_d;
	logic [8:0]  din_q, din_d; // measured input duty
	logic [8:0]  tgt_q, tgt_d; // target output duty
	logic [8:0]  tmin, tmax, dmin, dmax;

	// scaled endpoints of the curve
	always_comb begin
		tmin = 9'(fmd_muldiv(24'(omin_q), 24'(`FMD_DUTY_FULL), `FMD_TAG_DIV));
		tmax = 9'(fmd_muldiv(24'(omax_q), 24'(`FMD_DUTY_FULL), `FMD_TAG_DIV));
		dmin = 9'(fmd_muldiv(24'(imin_q), `FMD_THR_MUL, `FMD_THR_DIV)); // RQ8
		dmax = 9'(fmd_muldiv(24'(imax_q), `FMD_THR_MUL, `FMD_THR_DIV)) + `FMD_THR_HI_BASE; // RQ8
	end

	// measure once per input period; a stuck level reads as 0 or full duty
	always_comb begin
		per_d = (per_q == `FMD_IN_SAT) ? per_q : per_q + 16'h0001;
		hi_d  = (hi_q == `FMD_IN_SAT) ? hi_q : hi_q + 16'(pwm_s);
		din_d = din_q;
		if (pwm_rise) begin
			din_d = 9'(fmd_muldiv(24'(hi_q), 24'(`FMD_DUTY_FULL), 24'(per_q))); // RQ20
			per_d = 16'h0001;
			hi_d  = 16'h0001;
		end else if (per_q == `FMD_IN_SAT) begin
			din_d = pwm_s ? `FMD_DUTY_FULL : 9'h000;
		end
		if (din_q > dmax)
			tgt_d = full_q ? `FMD_DUTY_FULL : tmax; // RQ10
		else if (din_q < dmin)
			tgt_d = zero_q ? 9'h000 : tmin; // RQ11
		else
			tgt_d = tmin + 9'(fmd_muldiv(24'(tmax - tmin), 24'(din_q - dmin),
				24'(dmax - dmin))); // RQ9
	end

	// measurement registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			per_q    <= 16'h0000;
			hi_q     <= 16'h0000;
			din_q    <= 9'h000;
			tgt_q    <= 9'h000;
			pwm_p_q  <= 1'b0;
			hall_p_q <= 1'b0;
		end else begin
			per_q    <= per_d;
			hi_q     <= hi_d;
			din_q    <= din_d;
			tgt_q    <= tgt_d;
			pwm_p_q  <= pwm_s;
			hall_p_q <= hall_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode machine: spin detect, soft start ramp, steady slew
	fmd_pkg::fmd_mode_type mode_q, mode_d;
	fmd_pkg::fmd_duty_type duty_q, duty_d; // actual output duty
	logic [31:0] tmr_q, tmr_d;   // detect window or ramp step timer
	logic        seen_q, seen_d; // first hall edge seen while detecting
	logic [3:0]  edges_q, edges_d; // hall cycles during soft start
	logic [9:0]  pulses_q, pulses_d; // carrier pulses since last slew step
	logic [31:0] step_len; // ramp cycles per duty unit
	logic [8:0]  ramp_end;
	logic [9:0]  slew_len;
	logic        wrap;

	// ramp step interval from duration and span
	always_comb begin
		ramp_end = ramp_end_select ? `FMD_DUTY_END_HI : `FMD_DUTY_END_LO; // RQ2
		case (ramp_time_select) // RQ3
			2'h0:    step_len = ramp_end_select ? 32'(`FMD_RAMP_MS_FAST_HI * CLK_KHZ / SPAN_HI)
				: 32'(`FMD_RAMP_MS_FAST_LO * CLK_KHZ / SPAN_LO); // RQ21
			2'h1:    step_len = 32'(`FMD_RAMP_MS_MID * CLK_KHZ) / (ramp_end_select ?
				32'(SPAN_HI) : 32'(SPAN_LO));
			2'h2:    step_len = 32'(`FMD_RAMP_MS_LONG * CLK_KHZ) / (ramp_end_select ?
				32'(SPAN_HI) : 32'(SPAN_LO));
			default: step_len = 32'(`FMD_RAMP_MS_MAX * CLK_KHZ) / (ramp_end_select ?
				32'(SPAN_HI) : 32'(SPAN_LO));
		endcase
		case (slew_rate_select)
			2'h0:    slew_len = `FMD_SLEW_P0;
			2'h1:    slew_len = `FMD_SLEW_P1;
			default: slew_len = `FMD_SLEW_P2;
		endcase
	end

	// next state of the mode machine
	always_comb begin
		mode_d   = mode_q;
		duty_d   = duty_q;
		tmr_d    = tmr_q + 32'h0000_0001;
		seen_d   = seen_q;
		edges_d  = edges_q;
		pulses_d = pulses_q;
		case (mode_q)
			fmd_pkg::FMD_DETECT: begin
				if (hall_rise) begin
					seen_d = 1'b1;
					tmr_d  = 32'h0000_0000;
					if (seen_q && 64'(tmr_q) < SPIN_CYC) begin
						mode_d = fmd_pkg::FMD_STEADY; // RQ19
						duty_d = tgt_q;
					end
				end else if (64'(tmr_q) >= SPIN_CYC) begin
					mode_d = fmd_pkg::FMD_SOFT; // rotor slow or still
					duty_d = `FMD_DUTY_START; // RQ1
					tmr_d  = 32'h0000_0000;
				end
			end
			fmd_pkg::FMD_SOFT: begin
				if (hall_rise && edges_q != `FMD_SS_EDGES)
					edges_d = edges_q + 4'h1; // RQ5
				if (duty_q < ramp_end && tmr_q + 32'h0000_0001 >= step_len) begin
					duty_d = duty_q + 9'h001; // RQ4
					tmr_d  = 32'h0000_0000;
				end
				// leave only with end duty reached and enough hall cycles
				if (duty_q >= ramp_end && edges_q == `FMD_SS_EDGES)
					mode_d = fmd_pkg::FMD_STEADY; // RQ4 RQ5
			end
			fmd_pkg::FMD_STEADY: begin
				tmr_d = tmr_q;
				if (slew_rate_select == 2'h3) begin
					duty_d = tgt_q; // RQ13
				end else if (wrap) begin
					pulses_d = pulses_q + 10'h001;
					if (pulses_d >= slew_len) begin
						pulses_d = 10'h000;
						// same limiter covers the handover from the ramp
						if (duty_q < tgt_q)
							duty_d = duty_q + 9'h001; // RQ13 RQ14
						else if (duty_q > tgt_q)
							duty_d = duty_q - 9'h001; // RQ13 RQ14
					end
				end
			end
			default: mode_d = fmd_pkg::FMD_DETECT;
		endcase
	end

	// mode machine registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q   <= fmd_pkg::FMD_DETECT;
			duty_q   <= 9'h000;
			tmr_q    <= 32'h0000_0000;
			seen_q   <= 1'b0;
			edges_q  <= 4'h0;
			pulses_q <= 10'h000;
		end else begin
			mode_q   <= mode_d;
			duty_q   <= duty_d;
			tmr_q    <= tmr_d;
			seen_q   <= seen_d;
			edges_q  <= edges_d;
			pulses_q <= pulses_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// soft-switch taper around commutation
	logic [23:0] since_q, since_d; // cycles since last hall edge
	logic [23:0] comm_q, comm_d;   // length of last commutation period
	logic [23:0] rise_len, fall_len;
	logic [8:0]  shaped;
	logic [15:0] thr_q, thr_d;     // carrier compare threshold
	logic        pwm;
	logic        drive_a_d, drive_b_d;

	// each edge ends a period; tapers scale with the last period measured
	always_comb begin
		since_d  = hall_edge ? 24'h00_0000 : (since_q == 24'hFF_FFFF ? since_q
			: since_q + 24'h00_0001);
		comm_d   = hall_edge ? since_q : comm_q;
		// wide product: slow rotors give long periods whose product with the taper numerator overflows 24 bits
		rise_len = 24'((48'(comm_q) * 48'(fmd_interp(rise_taper_at_min, rise_taper_at_max,
			duty_q, tmin, tmax))) >> `FMD_TAPER_SHIFT); // RQ16
		fall_len = 24'((48'(comm_q) * 48'(fmd_interp(fall_taper_at_min, fall_taper_at_max,
			duty_q, tmin, tmax))) >> `FMD_TAPER_SHIFT); // RQ16
		shaped   = duty_q;
		if (comm_q != 24'h00_0000 && since_q < comm_q) begin
			if (since_q < rise_len)
				shaped = 9'(fmd_muldiv(24'(duty_q), since_q, rise_len)); // RQ15
			else if (comm_q - since_q < fall_len)
				shaped = 9'(fmd_muldiv(24'(duty_q), comm_q - since_q, fall_len)); // RQ15
		end
		thr_d     = 16'(fmd_muldiv(24'(shaped), 24'(PERIOD), 24'(`FMD_DUTY_FULL)));
		drive_a_d = pwm & hall_s;
		drive_b_d = pwm & ~hall_s;
	end

	// taper registers and outputs
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			since_q    <= 24'h00_0000;
			comm_q     <= 24'h00_0000;
			thr_q      <= 16'h0000;
			drive_a_q  <= 1'b0;
			drive_b_q  <= 1'b0;
			steady_q   <= 1'b0;
			duty_now_q <= 9'h000;
		end else begin
			since_q    <= since_d;
			comm_q     <= comm_d;
			thr_q      <= thr_d;
			drive_a_q  <= drive_a_d;
			drive_b_q  <= drive_b_d;
			steady_q   <= (mode_d == fmd_pkg::FMD_STEADY);
			duty_now_q <= duty_d;
		end
	end

	fmd_carrier #(.PERIOD(PERIOD)) u_carrier (
		.clk    (clk),
		.arst_n (arst_n),
		.thresh (thr_q),
		.pwm_q  (pwm),
		.wrap_q (wrap)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_soft_start_duty: assert property (@(posedge clk) disable iff (!arst_n) // RQ1
		(mode_q == fmd_pkg::FMD_DETECT && mode_d == fmd_pkg::FMD_SOFT)
		|=> duty_q == `FMD_DUTY_START) else $error("soft start not at start duty");
	a_soft_end_cap: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
		mode_q == fmd_pkg::FMD_SOFT |-> duty_q <= ramp_end) else $error("ramp past end");
	a_ramp_linear: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
		(mode_q == fmd_pkg::FMD_SOFT && $past(mode_q) == fmd_pkg::FMD_SOFT && $changed(duty_q))
		|-> duty_q == $past(duty_q) + 9'h001) else $error("ramp step not one unit");
	a_soft_min_edges: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
		(mode_q == fmd_pkg::FMD_SOFT ##1 mode_q == fmd_pkg::FMD_STEADY)
		|-> $past(edges_q) == `FMD_SS_EDGES) else $error("soft start left early");
	a_above_range: assert property (@(posedge clk) disable iff (!arst_n) // RQ10
		(din_q > dmax && full_q && $stable(full_q)) |=> tgt_q == `FMD_DUTY_FULL)
		else $error("above range target wrong");
	a_below_range: assert property (@(posedge clk) disable iff (!arst_n) // RQ11
		(din_q < dmin && zero_q && $stable(zero_q)) |=> tgt_q == 9'h000)
		else $error("below range target wrong");
	a_slew_step: assert property (@(posedge clk) disable iff (!arst_n) // RQ13
		(mode_q == fmd_pkg::FMD_STEADY && slew_rate_select != 2'h3 && !wrap)
		|=> $stable(duty_q) || $past(mode_q) != fmd_pkg::FMD_STEADY)
		else $error("duty moved between pulses");
	a_phase_excl: assert property (@(posedge clk) disable iff (!arst_n) // RQ15
		!(drive_a_q && drive_b_q)) else $error("both phases driven");
endmodule

// File: tb/fmd_cmd_source.sv
`timescale 1ns/1ps
// stand-in for the system controller pwm and the hall sensor
module fmd_cmd_source #(
	parameter int HALL_HALF = 100
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] period,
	input  wire logic [15:0] high_len,
	input  wire logic        hall_run,
	output logic             pwm_in,
	output logic             hall_in
);
	logic [15:0] pcnt_q; // position inside the pwm period
	logic [15:0] hcnt_q; // position inside half a hall cycle
	////////////////////////////////////////////////////////////////
	// the period is chosen by the bench inside the 7 to 40 kHz band
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pcnt_q  <= 16'h0000;
			hcnt_q  <= 16'h0000;
			pwm_in  <= 1'b0;
			hall_in <= 1'b0;
		end else begin
			pcnt_q <= (pcnt_q + 16'h0001 >= period) ? 16'h0000 : pcnt_q + 16'h0001;
			pwm_in <= (pcnt_q < high_len);
			// fast hall so the rotor looks spinning; hall_run low holds it still
			if (hall_run && hcnt_q == 16'(HALL_HALF - 1)) begin
				hcnt_q  <= 16'h0000;
				hall_in <= ~hall_in;
			end else if (hall_run) begin
				hcnt_q <= hcnt_q + 16'h0001;
			end
		end
	end
endmodule

// File: tb/tb_fmd_duty_ctrl.sv
`timescale 1ns/1ps
module tb_fmd_duty_ctrl;
	logic        clk;              // 40 MHz bench clock
	logic        arst_n;           // active low reset
	logic        pwm_in;           // from the source model
	logic        hall_in;          // from the source model
	logic [15:0] reg_addr;         // register address
	logic [7:0]  reg_wdata;        // write data
	logic        reg_we;           // write strobe
	logic [1:0]  slew_rate_select; // rate of change code
	logic        ramp_end_select;  // soft start end duty pick
	logic [1:0]  ramp_time_select; // soft start duration code
	logic [3:0]  taper_code;       // shared by all four taper codes
	logic        hall_run;         // low holds the hall model still
	logic [15:0] period;           // command pwm period in cycles
	logic [15:0] high_len;         // command pwm high time in cycles
	logic [7:0]  reg_rdata_q;
	logic        drive_a_q;
	logic        drive_b_q;
	logic        steady_q;
	logic [8:0]  duty_now_q;
	int          n_errors;
	int          total_checks;
	int          cyc;
	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// short clock scale: carrier becomes 8 cycles; many poles shorten spin detect
	fmd_duty_ctrl #(.CLK_KHZ(400), .POLES(40)) i_dut (
		.clk(clk), .arst_n(arst_n), .pwm_in(pwm_in), .hall_in(hall_in),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.ramp_end_select(ramp_end_select), .ramp_time_select(ramp_time_select),
		.slew_rate_select(slew_rate_select),
		.rise_taper_at_max(taper_code), .rise_taper_at_min(taper_code),
		.fall_taper_at_max(taper_code), .fall_taper_at_min(taper_code),
		.reg_rdata_q(reg_rdata_q), .drive_a_q(drive_a_q), .drive_b_q(drive_b_q),
		.steady_q(steady_q), .duty_now_q(duty_now_q)
	);
	fmd_cmd_source #(.HALL_HALF(100)) i_src (
		.clk(clk), .arst_n(arst_n), .period(period), .high_len(high_len), .hall_run(hall_run),
		.pwm_in(pwm_in), .hall_in(hall_in)
	);
	////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one write: strobe high for exactly one edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_we    <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	// read data is registered, so hold the address two edges
	task automatic rd(input string name, input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		repeat (2) @(posedge clk);
		#1;
		check(name, {8'h00, reg_rdata_q}, {8'h00, exp});
	endtask
	// new command duty; wait for two input periods plus the update
	task automatic cmd(input logic [15:0] hi);
		@(posedge clk);
		high_len <= hi;
		repeat (3000) @(posedge clk);
		#1;
	endtask
	// edge spacing of the bridge drive in mid commutation
	task automatic carrier_check();
		logic prev;
		int   first;
		int   gap;
		int   both;
		prev  = 1'b1;
		first = -1;
		gap   = 0;
		both  = 0;
		@(posedge hall_in);
		repeat (30) @(posedge clk);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			#1;
			if (drive_a_q === 1'b1 && prev === 1'b0) begin
				if (first < 0)
					first = i;
				else if (gap == 0)
					gap = i - first;
			end
			if (drive_b_q !== 1'b0)
				both++;
			prev = drive_a_q;
		end
		check("carrier period", gap[15:0], 16'h0008);
		check("opposite drive", both[15:0], 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	// hang guard, the tests need about 31000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		n_errors         = 0;
		total_checks     = 0;
		cyc              = 0;
		arst_n           = 1'b0;
		reg_addr         = 16'h0000;
		reg_wdata        = 8'h00;
		reg_we           = 1'b0;
		slew_rate_select = 2'h3;
		ramp_end_select  = 1'b0;
		ramp_time_select = 2'h0;
		taper_code       = 4'h0;
		hall_run         = 1'b1;
		period           = 16'd1000;
		high_len         = 16'd300;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		// reset values, then unused bits and an unmapped place
		rd("tag low", 16'h0100, 8'h00);
		rd("tag high", 16'h0101, 8'hFE);
		rd("thr low", 16'h0102, 8'h00);
		rd("thr high", 16'h0103, 8'h7E);
		rd("range flags", 16'h0108, 8'h00);
		wr(16'h0104, 8'hFF);
		rd("unmapped", 16'h0104, 8'h00);
		wr(16'h0103, 8'hFF);
		rd("thr high mask", 16'h0103, 8'h7E);
		wr(16'h0108, 8'hFF);
		rd("flags mask", 16'h0108, 8'h0C);
		wr(16'h0108, 8'h00);
		// spinning rotor skips the ramp; default map is identity
		cmd(16'd300);
		check("steady", {15'h0000, steady_q}, 16'h0001);
		check("in range duty", {7'h00, duty_now_q}, 16'd150);
		carrier_check();
		// low threshold 32 gives 126 units, low duty code 20 gives 78
		wr(16'h0102, 8'h40);
		wr(16'h0100, 8'h28);
		cmd(16'd100);
		check("below hold", {7'h00, duty_now_q}, 16'd78);
		wr(16'h0108, 8'h08);
		cmd(16'd100);
		check("below zero", {7'h00, duty_now_q}, 16'd0);
		// high threshold 0 gives 251 units, high duty code 100 gives 393
		wr(16'h0102, 8'h00);
		wr(16'h0103, 8'h00);
		wr(16'h0101, 8'hC8);
		wr(16'h0108, 8'h00);
		cmd(16'd900);
		check("above hold", {7'h00, duty_now_q}, 16'd393);
		wr(16'h0108, 8'h04);
		cmd(16'd900);
		check("above full", {7'h00, duty_now_q}, 16'd500);
		// back to identity, then slow slew from 150 toward 200
		wr(16'h0100, 8'h00);
		wr(16'h0101, 8'hFE);
		wr(16'h0102, 8'h00);
		wr(16'h0103, 8'h7E);
		wr(16'h0108, 8'h00);
		cmd(16'd300);
		@(posedge clk);
		slew_rate_select <= 2'h0;
		repeat (2) @(posedge clk);
		high_len <= 16'd400;
		// 1024 cycles per unit; the first step lands anywhere in a group
		repeat (5000) @(posedge clk);
		#1;
		check("slow slew", {15'h0000, duty_now_q >= 9'd152 && duty_now_q <= 9'd156}, 16'h0001);
		@(posedge clk);
		slew_rate_select <= 2'h3;
		repeat (20) @(posedge clk);
		#1;
		check("jump slew", {7'h00, duty_now_q}, 16'd200);
		// second reset with the rotor still: detect times out into the ramp
		@(posedge clk);
		arst_n           <= 1'b0;
		hall_run         <= 1'b0;
		ramp_time_select <= 2'h3;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		// longest ramp code holds the start duty well past the window
		repeat (4200) @(posedge clk);
		#1;
		check("ramp start", {7'h00, duty_now_q}, 16'd20);
		@(posedge clk);
		ramp_time_select <= 2'h0;
		// fastest code: 8 cycles per unit, 100 units to the low end duty
		repeat (1000) @(posedge clk);
		#1;
		check("ramp end", {7'h00, duty_now_q}, 16'd120);
		check("held in soft start", {15'h0000, steady_q}, 16'h0000);
		@(posedge clk);
		hall_run <= 1'b1;
		// eight hall cycles of 200 clocks each release the ramp
		repeat (2500) @(posedge clk);
		#1;
		check("ramp exit", {15'h0000, steady_q}, 16'h0001);
		give_verdict();
	end
endmodule
